// ---- shared/stepper_params.svh ----
// Constants for the stepper excitation sequencer
`ifndef STEPPER_PARAMS_SVH
`define STEPPER_PARAMS_SVH

// ----------------------------------------------------------------------
// Pin sampling
// ----------------------------------------------------------------------
`define PIN_W 7
`define PIN_STEP 0
`define PIN_DIR 1
`define PIN_MODE_A 2
`define PIN_MODE_B 3
`define PIN_EDGE 4
`define PIN_EN 5
`define PIN_RST 6
// Reset pin idles high, every other pin idles low
`define PIN_RESET_VAL 7'h40

// ----------------------------------------------------------------------
// Phase position and current ratio
// ----------------------------------------------------------------------
`define POS_W 6
`define POS_RESET 6'h00
`define QTR_MSB 5
`define QTR_LSB 4
`define SUB_MSB 3
`define SUB_ZERO 4'h0
`define SUB_MID 4'h8
`define IDX_W 5
`define IDX_QUARTER 5'h10
`define STEP_FULL 6'h10
`define STEP_HALF 6'h08
`define STEP_W12 6'h04
`define STEP_2W12 6'h02
`define STEP_4W12 6'h01
`define RATIO_W 7
`define RATIO_OFF 7'h00
`define RATIO_FULL 7'h64
`define RATIO_PSEUDO 7'h47
// Percent for k = 16 down to 0, k = 0 at the low end
`define RATIO_TABLE {7'h64, 7'h64, 7'h61, 7'h5F, 7'h5D, 7'h57, 7'h53, \
	7'h4D, 7'h47, 7'h40, 7'h37, 7'h2F, 7'h28, 7'h1E, 7'h14, 7'h0B, 7'h00}
`define DRIVE_W 4
`define DRIVE_OFF 4'h0

`endif

// ---- shared/stepper_pkg.sv ----
// Types for the stepper excitation sequencer
`include "stepper_params.svh"
package stepper_pkg;

	typedef enum logic [2:0] {
		MODE_FULL2,
		MODE_HALF_FULL,
		MODE_HALF_PSEUDO,
		MODE_W12,
		MODE_2W12,
		MODE_4W12
	} step_mode_t;

	typedef struct packed {
		logic [`PIN_W-1:0] sync1;
		logic [`PIN_W-1:0] sync2;
		logic [`PIN_W-1:0] sync3;
		logic [`PIN_W-1:0] filt;
		logic [`POS_W-1:0] pos;
		logic [`DRIVE_W-1:0] drive;
		logic [`RATIO_W-1:0] ratio_a;
		logic [`RATIO_W-1:0] ratio_b;
	} state_t;

endpackage

// ---- core/stepper_excitation_sequencer.sv ----
// Step sequencer: phase position, excitation mode and chopping current ratio
// ----------------------------------------------------------------------
// Overview of operation
// - Edge select high decodes four rising modes
// - Edge select low decodes four both-edge modes
// - Rising edges only, or both edges, advance
// - Half step rising: energised phases at full
// - Half step both edges: full or reduced
// - Ratio 100 equals reference peak current
// - Sixteenth-angle current ratio table applies
// - Enable low forces all drives off
// - Power-on reset initialises; reset pin combined
// - Direction 0 clockwise, 1 counterclockwise
// - Enable low holds phase position unless reset pin low
// ----------------------------------------------------------------------
`include "stepper_params.svh"
module stepper_excitation_sequencer
	import stepper_pkg::*;
(
	// Clock, power-on reset, clock enable
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	// Controller pins
	input wire logic step_clock_i,
	input wire logic direction_input_i,
	input wire logic step_mode_select_pin_a_i,
	input wire logic step_mode_select_pin_b_i,
	input wire logic edge_select_pin_i,
	input wire logic motor_enable_i,
	input wire logic reset_n_input_i,
	// Excitation drives {a, ab, b, bb} and ratios in percent of peak
	output logic [`DRIVE_W-1:0] phase_drive_o,
	output logic [`RATIO_W-1:0] ratio_a_o,
	output logic [`RATIO_W-1:0] ratio_b_o,
	output logic [`POS_W-1:0] phase_pos_o
);

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------
	function automatic step_mode_t decode_mode(input logic edge_sel,
		input logic [1:0] code);
		step_mode_t m;
		m = MODE_FULL2;
		if (edge_sel)
		begin
			case (code)
				2'h0: m = MODE_FULL2;
				2'h1: m = MODE_HALF_FULL;
				2'h2: m = MODE_W12;
				default: m = MODE_2W12;
			endcase
		end
		else
		begin
			case (code)
				2'h0: m = MODE_HALF_PSEUDO;
				2'h1: m = MODE_W12;
				2'h2: m = MODE_2W12;
				default: m = MODE_4W12;
			endcase
		end
		return m;
	endfunction

	function automatic logic [`POS_W-1:0] step_size(input step_mode_t m);
		logic [`POS_W-1:0] s;
		s = `STEP_FULL;
		case (m)
			MODE_FULL2: s = `STEP_FULL;
			MODE_HALF_FULL: s = `STEP_HALF;
			MODE_HALF_PSEUDO: s = `STEP_HALF;
			MODE_W12: s = `STEP_W12;
			MODE_2W12: s = `STEP_2W12;
			MODE_4W12: s = `STEP_4W12;
			default: s = `STEP_FULL;
		endcase
		return s;
	endfunction

	// Ratio is percent of the reference peak current
	function automatic logic [`RATIO_W-1:0] ratio_of(input step_mode_t m,
		input logic [`IDX_W-1:0] idx);
		logic [17*`RATIO_W-1:0] tab;
		logic [`RATIO_W-1:0] r;
		tab = `RATIO_TABLE;
		r = tab[idx*`RATIO_W +: `RATIO_W];
		if (m == MODE_FULL2)
			r = `RATIO_FULL;
		else if (m == MODE_HALF_FULL && idx != '0)
			r = `RATIO_FULL;
		return r;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	state_t q_reg;
	state_t q_next;
	logic [`PIN_W-1:0] pins;
	logic [`PIN_W-1:0] filt_new;
	logic int_rst;
	logic enabled;
	logic step_evt;
	step_mode_t mode;
	logic [1:0] quarter;
	logic [`IDX_W-1:0] sub;
	logic [`IDX_W-1:0] cos_idx;
	logic [`IDX_W-1:0] sin_idx;
	logic [`RATIO_W-1:0] mag_a;
	logic [`RATIO_W-1:0] mag_b;
	logic a_pos;
	logic b_pos;

	assign pins = {reset_n_input_i, motor_enable_i, edge_select_pin_i,
		step_mode_select_pin_b_i, step_mode_select_pin_a_i,
		direction_input_i, step_clock_i};

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		q_next = q_reg;
		q_next.sync1 = pins;
		q_next.sync2 = q_reg.sync1;
		q_next.sync3 = q_reg.sync2;
		// A pin change is taken once the 2nd and 3rd stages agree
		for (int i = 0; i < `PIN_W; i++)
			filt_new[i] = (q_reg.sync2[i] == q_reg.sync3[i]) ?
				q_reg.sync3[i] : q_reg.filt[i];
		q_next.filt = filt_new;
		int_rst = !filt_new[`PIN_RST];
		enabled = filt_new[`PIN_EN];
		mode = decode_mode(filt_new[`PIN_EDGE],
			{filt_new[`PIN_MODE_B], filt_new[`PIN_MODE_A]});
		// Steps only while enabled, so disabled inputs cannot move phase
		step_evt = enabled &&
			(filt_new[`PIN_STEP] != q_reg.filt[`PIN_STEP]) &&
			(filt_new[`PIN_STEP] || !filt_new[`PIN_EDGE]);
		if (int_rst)
			q_next.pos = `POS_RESET;
		else if (step_evt)
		begin
			if (filt_new[`PIN_DIR])
				q_next.pos = q_reg.pos - step_size(mode);
			else
				q_next.pos = q_reg.pos + step_size(mode);
		end
		quarter = q_next.pos[`QTR_MSB:`QTR_LSB];
		sub = {1'b0, q_next.pos[`SUB_MSB:0]};
		cos_idx = `IDX_QUARTER - sub;
		sin_idx = sub;
		if (quarter[0])
		begin
			cos_idx = sub;
			sin_idx = `IDX_QUARTER - sub;
		end
		mag_a = ratio_of(mode, cos_idx);
		mag_b = ratio_of(mode, sin_idx);
		a_pos = (quarter == 2'h0) || (quarter == 2'h3);
		b_pos = !quarter[1];
		if (!enabled || int_rst)
		begin
			q_next.drive = `DRIVE_OFF;
			q_next.ratio_a = `RATIO_OFF;
			q_next.ratio_b = `RATIO_OFF;
		end
		else
		begin
			q_next.drive = {a_pos && mag_a != '0, !a_pos && mag_a != '0,
				b_pos && mag_b != '0, !b_pos && mag_b != '0};
			q_next.ratio_a = mag_a;
			q_next.ratio_b = mag_b;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			q_reg <= '0;
			q_reg.sync1 <= `PIN_RESET_VAL;
			q_reg.sync2 <= `PIN_RESET_VAL;
			q_reg.sync3 <= `PIN_RESET_VAL;
			q_reg.filt <= `PIN_RESET_VAL;
		end
		else if (clk_en_i)
			q_reg <= q_next;
	end

	assign phase_drive_o = q_reg.drive;
	assign ratio_a_o = q_reg.ratio_a;
	assign ratio_b_o = q_reg.ratio_b;
	assign phase_pos_o = q_reg.pos;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_disabled_drive_off: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) !q_reg.filt[`PIN_EN] |->
		(phase_drive_o == `DRIVE_OFF && ratio_a_o == `RATIO_OFF &&
		ratio_b_o == `RATIO_OFF))
		else $error("drive active while disabled");

	chk_disabled_pos_hold: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) (clk_en_i && !filt_new[`PIN_EN] &&
		filt_new[`PIN_RST]) |=> $stable(phase_pos_o))
		else $error("phase moved while disabled");

	chk_rising_only: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) (clk_en_i && filt_new[`PIN_EDGE] &&
		filt_new[`PIN_RST] && !filt_new[`PIN_STEP]) |=>
		$stable(phase_pos_o))
		else $error("phase moved without rising edge");

	chk_cw_advance: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) (clk_en_i && step_evt && !int_rst &&
		!filt_new[`PIN_DIR]) |=>
		phase_pos_o == $past(q_reg.pos) + $past(step_size(mode)))
		else $error("clockwise step size wrong");

	chk_fine_step: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) (clk_en_i && step_evt && !int_rst &&
		mode == MODE_4W12 && filt_new[`PIN_DIR]) |=>
		phase_pos_o == $past(q_reg.pos) - `STEP_4W12)
		else $error("fine step not one sixteenth");

	chk_half_full: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) (clk_en_i && mode == MODE_HALF_FULL &&
		enabled && !int_rst) |=> (ratio_a_o == `RATIO_FULL ||
		ratio_a_o == `RATIO_OFF) && (ratio_b_o == `RATIO_FULL ||
		ratio_b_o == `RATIO_OFF))
		else $error("half step current not full");

	chk_pseudo_mid: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) (clk_en_i && mode == MODE_HALF_PSEUDO &&
		enabled && !int_rst && q_next.pos[`SUB_MSB:0] == `SUB_MID) |=>
		ratio_a_o == `RATIO_PSEUDO && ratio_b_o == `RATIO_PSEUDO)
		else $error("pseudo micro level wrong");

	chk_quarter_peak: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) (clk_en_i && mode != MODE_FULL2 &&
		enabled && !int_rst && q_next.pos[`SUB_MSB:0] == `SUB_ZERO) |=>
		(phase_pos_o[`QTR_LSB] ? (ratio_a_o == `RATIO_OFF &&
		ratio_b_o == `RATIO_FULL) : (ratio_a_o == `RATIO_FULL &&
		ratio_b_o == `RATIO_OFF)))
		else $error("quarter point ratio wrong");

	chk_pin_reset: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) (clk_en_i && int_rst) |=>
		phase_pos_o == `POS_RESET && phase_drive_o == `DRIVE_OFF)
		else $error("reset pin did not clear phase");

endmodule

// ---- bench/step_host.sv ----
// Host controller model that issues step clock edges on request
module step_host (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Request from the bench
	input wire logic go_i,
	// Step pin and pacing
	output logic step_clock_o,
	output logic busy_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] wait_reg;

	assign busy_o = wait_reg != 4'h0;

	// Quiet time after reset, and spacing so other pins settle around edges
	always @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			step_clock_o <= 1'b0;
			wait_reg <= 4'hF;
		end
		else if (busy_o)
			wait_reg <= wait_reg - 4'h1;
		else if (go_i)
		begin
			step_clock_o <= ~step_clock_o;
			wait_reg <= 4'h8;
		end
	end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the step sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic dir = 1'b0;
	logic ma = 1'b0;
	logic mb = 1'b0;
	logic edge_sel = 1'b1;
	logic en = 1'b1;
	logic rst_pin = 1'b1;
	logic go = 1'b0;
	logic step, busy, lvl;
	logic [3:0] drive;
	logic [6:0] ra, rb;
	logic [5:0] pos, epos, held;
	logic [31:0] r;
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	logic [6:0] tab [17] = '{7'h00, 7'h0B, 7'h14, 7'h1E, 7'h28, 7'h2F,
		7'h37, 7'h40, 7'h47, 7'h4D, 7'h53, 7'h57, 7'h5D, 7'h5F, 7'h61,
		7'h64, 7'h64};

	always #2 clk = ~clk;

	step_host host (.clk_i(clk), .rst_b_i(rst_b), .go_i(go),
		.step_clock_o(step), .busy_o(busy));

	stepper_excitation_sequencer dut (.clk_i(clk), .rst_b_i(rst_b),
		.clk_en_i(clk_en), .step_clock_i(step), .direction_input_i(dir),
		.step_mode_select_pin_a_i(ma), .step_mode_select_pin_b_i(mb),
		.edge_select_pin_i(edge_sel), .motor_enable_i(en),
		.reset_n_input_i(rst_pin), .phase_drive_o(drive),
		.ratio_a_o(ra), .ratio_b_o(rb), .phase_pos_o(pos));

	// --------
	// Expectations and checks
	// --------
	function automatic logic [6:0] exp_r(input logic [5:0] p,
		input logic b);
		logic [4:0] k;
		k = (p[4] ^ b) ? {1'b0, p[3:0]} : 5'h10 - {1'b0, p[3:0]};
		if ({edge_sel, mb, ma} == 3'h4)
			return 7'h64;
		if ({edge_sel, mb, ma} == 3'h5 && tab[k] != 7'h00)
			return 7'h64;
		return tab[k];
	endfunction

	// Phase A positive in quarters 0 and 3, phase B in quarters 0 and 1
	function automatic logic [3:0] exp_d(input logic [5:0] p);
		logic a_on;
		logic b_on;
		logic a_pos;
		logic b_pos;
		a_on = exp_r(p, 1'b0) != 7'h00;
		b_on = exp_r(p, 1'b1) != 7'h00;
		a_pos = p[5] == p[4];
		b_pos = !p[5];
		return {a_pos && a_on, !a_pos && a_on, b_pos && b_on, !b_pos && b_on};
	endfunction

	task automatic check(input logic [6:0] got, input logic [6:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask

	task automatic check_all();
		check({1'b0, pos}, {1'b0, epos});
		check(ra, exp_r(epos, 1'b0));
		check(rb, exp_r(epos, 1'b1));
		check({3'h0, drive}, {3'h0, exp_d(epos)});
	endtask

	// Pins are left quiet a few cycles before each edge
	task automatic step_once(input logic live);
		logic [5:0] st;
		st = (edge_sel ? 6'h10 : 6'h08) >> {mb, ma};
		repeat (4) @(negedge clk);
		while (busy) @(negedge clk);
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		lvl = ~lvl;
		if (live && (lvl || !edge_sel))
			epos = dir ? epos - st : epos + st;
		repeat (10) @(negedge clk);
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	// --------
	// Main sequence: every mode setting in both directions (half step rising and 2W12 rising only get falling edges, so never step), then random ones
	// --------
	initial
	begin
		r = $urandom(32'h919de970);
		lvl = 1'b0;
		epos = 6'h00;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		for (int i = 0; i < 48; i++)
		begin
			r = (i < 16) ? i : $urandom;
			{edge_sel, mb, ma} = r[2:0];
			dir = r[3];
			step_once(1'b1);
			check_all();
		end
		edge_sel = 1'b0;
		en = 1'b0;
		step_once(1'b0);
		check({3'h0, drive}, 7'h00);
		check(ra | rb, 7'h00);
		check({1'b0, pos}, {1'b0, epos});
		en = 1'b1;
		repeat (10) @(negedge clk);
		check_all();
		if (lvl)
			step_once(1'b1);
		rst_pin = 1'b0;
		repeat (10) @(negedge clk);
		check({1'b0, pos}, 7'h00);
		check(ra | rb, 7'h00);
		check({3'h0, drive}, 7'h00);
		rst_pin = 1'b1;
		epos = 6'h00;
		repeat (10) @(negedge clk);
		step_once(1'b1);
		check_all();
		held = epos;
		clk_en = 1'b0;
		step_once(1'b1);
		check({1'b0, pos}, {1'b0, held});
		clk_en = 1'b1;
		repeat (10) @(negedge clk);
		check_all();
		report_and_stop();
	end
endmodule
